// [src/pmst_pkg.sv]
// Package with register map, field positions and timing constants.
package pmst_pkg;

	localparam logic [5:0] PMST_ADDR_FILTER = 6'h2C;
	localparam logic [5:0] PMST_ADDR_POWER = 6'h2D;
	localparam logic [5:0] PMST_ADDR_SELFTEST = 6'h2E;
	localparam logic [5:0] PMST_ADDR_MOTION_CTL = 6'h27;

	localparam logic [7:0] PMST_POWER_RESET = 8'h00;
	localparam logic [7:0] PMST_SELFTEST_RESET = 8'h00;
	localparam logic [7:0] PMST_FILTER_RESET = 8'h13;
	localparam logic [7:0] PMST_MOTION_RESET = 8'h00;

	localparam int PMST_BIT_CONV_EN = 7;
	localparam int PMST_BIT_EXT_TB = 6;
	localparam int PMST_NOISE_HI = 5;
	localparam int PMST_NOISE_LO = 4;
	localparam int PMST_BIT_POLL = 3;
	localparam int PMST_BIT_AUTOSLEEP = 2;
	localparam int PMST_ACQ_HI = 1;
	localparam int PMST_ACQ_LO = 0;
	localparam int PMST_BIT_STIM = 0;
	localparam int PMST_BIT_OUTSIDE_SAMPLE_TRIGGER_ON = 3;
	localparam int PMST_ODR_HI = 2;
	localparam int PMST_ODR_LO = 0;
	localparam int PMST_BIT_HALF_BW = 4;
	// Link and loop mode bits of the motion detect control register.
	localparam int PMST_LINK_HI = 5;
	localparam int PMST_LINK_LO = 4;

	localparam logic [1:0] PMST_ACQ_STANDBY = 2'h0;
	localparam logic [1:0] PMST_ACQ_ACQUISITION_SELECT = 2'h2;

	typedef enum logic [1:0]
	{
		PMST_NOISE_NORMAL = 2'h0,
		PMST_NOISE_LOW = 2'h1,
		PMST_NOISE_ULTRA = 2'h2,
		PMST_NOISE_RSVD = 2'h3
	} pmst_noise_type;

	// Internal timebase: 51.2 kHz ticks from the 50 MHz clock.
	localparam int PMST_CLK_HZ = 50000000;
	localparam int PMST_TB_HZ = 51200;
	localparam int PMST_TB_DIV = PMST_CLK_HZ / PMST_TB_HZ;
	// 100 Hz ODR is 512 timebase ticks; other rates shift this.
	localparam int PMST_TICKS_100HZ = 512;
	// Wake-up polling near six samples per second.
	localparam int PMST_TICKS_POLL = 8533;
	localparam int PMST_TICK_W = 14;

	typedef enum logic [1:0]
	{
		PMST_ST_STANDBY = 2'h0,
		PMST_ST_ACQUISITION_SELECT = 2'h1,
		PMST_ST_POLL = 2'h2
	} pmst_state_type;

	typedef struct packed
	{
		logic acquire;
		logic convert;
		logic stimulus;
		logic [1:0] noise;
		logic [2:0] filter_bw;
		logic half_bw;
	} pmst_ctl_type;

endpackage

// [src/pmst_sync_edge.sv]
// Two-flop synchroniser with rising-edge pulse.
module pmst_sync_edge
(
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o
);

	logic meta_r;
	logic sync_r;
	logic prev_r;

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end
		else
		begin
			meta_r <= async_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level_o = sync_r;
	assign rise_o = sync_r & ~prev_r;

endmodule

// [src/pmst_rate_gen.sv]
// Sample period counter driven by a timebase tick.
module pmst_rate_gen
(
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic [13:0] period_i,
	output logic strobe_o
);

	logic [13:0] cnt_r;

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i || !run_i)
		begin
			cnt_r <= 14'h0000;
			strobe_o <= 1'b0;
		end
		else
		begin
			strobe_o <= 1'b0;
			if (tick_i)
			begin
				if (cnt_r >= period_i - 14'h0001)
				begin
					cnt_r <= 14'h0000;
					strobe_o <= 1'b1;
				end
				else
				begin
					cnt_r <= cnt_r + 14'h0001;
				end
			end
		end
	end

endmodule

// [src/pmst_top.sv]
// Power mode control register, timebase selection and sample triggering.
module pmst_top
(
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic wr_en_i,
	input wire logic [5:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic inactivity_i,
	input wire logic irq_pin_a_i,
	input wire logic irq_pin_b_i,
	output logic irq_pin_b_oe_n_o,
	output logic sample_o,
	output logic convert_o,
	output logic stimulus_o,
	output logic [1:0] noise_o,
	output logic low_rate_poll_mode_o,
	output logic ext_timebase_o,
	output logic [3:0] filter_bw_o
);

	logic [7:0] power_mode_control_r;
	logic [7:0] built_in_force_check_r;
	logic [7:0] filter_and_rate_control_r;
	logic [7:0] motion_detect_control_r;
	logic [7:0] rdata_nxt;
	logic [9:0] tb_div_r;
	logic int_tick_r;
	logic ext_rise;
	logic trig_rise;
	logic tick;
	logic rate_strobe;
	logic [13:0] period;
	logic auto_ok;
	logic auto_poll_r;
	logic poll_mode;
	logic measuring;
	logic ext_trig_on;
	pmst_pkg::pmst_state_type state_r;
	pmst_pkg::pmst_ctl_type ctl;

	// Register writes; autosleep entry clears on srst_i or when auto_ok or inactivity_i drops.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			power_mode_control_r <= pmst_pkg::PMST_POWER_RESET;
			built_in_force_check_r <= pmst_pkg::PMST_SELFTEST_RESET;
			filter_and_rate_control_r <= pmst_pkg::PMST_FILTER_RESET;
			motion_detect_control_r <= pmst_pkg::PMST_MOTION_RESET;
		end
		else if (wr_en_i)
		begin
			case (addr_i)
				pmst_pkg::PMST_ADDR_POWER:
					power_mode_control_r <= wdata_i;
				pmst_pkg::PMST_ADDR_SELFTEST:
					built_in_force_check_r <= wdata_i;
				pmst_pkg::PMST_ADDR_FILTER:
					filter_and_rate_control_r <= wdata_i;
				pmst_pkg::PMST_ADDR_MOTION_CTL:
					motion_detect_control_r <= wdata_i;
				default:
					;
			endcase
		end
	end

	always_comb
	begin
		case (addr_i)
			pmst_pkg::PMST_ADDR_POWER:
				rdata_nxt = power_mode_control_r;
			pmst_pkg::PMST_ADDR_SELFTEST:
				rdata_nxt = built_in_force_check_r;
			pmst_pkg::PMST_ADDR_FILTER:
				rdata_nxt = filter_and_rate_control_r;
			pmst_pkg::PMST_ADDR_MOTION_CTL:
				rdata_nxt = motion_detect_control_r;
			default:
				rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			rdata_o <= 8'h00;
		else
			rdata_o <= rdata_nxt;
	end

	// Internal timebase divider.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			tb_div_r <= 10'h000;
			int_tick_r <= 1'b0;
		end
		else if (tb_div_r == 10'(pmst_pkg::PMST_TB_DIV - 1))
		begin
			tb_div_r <= 10'h000;
			int_tick_r <= 1'b1;
		end
		else
		begin
			tb_div_r <= tb_div_r + 10'h001;
			int_tick_r <= 1'b0;
		end
	end

	pmst_sync_edge u_outside_timebase_select
	(
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.async_i(irq_pin_a_i),
		.level_o(),
		.rise_o(ext_rise)
	);

	// Trigger input, active high, one acquisition per rising edge.
	pmst_sync_edge u_trig
	(
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.async_i(irq_pin_b_i),
		.level_o(),
		.rise_o(trig_rise)
	);

	// Timebase source follows the external select bit.
	assign tick = power_mode_control_r[pmst_pkg::PMST_BIT_EXT_TB] ? ext_rise
		: int_tick_r;

	// Autosleep only counts when motion detection is linked or looped.
	assign auto_ok = power_mode_control_r[pmst_pkg::PMST_BIT_AUTOSLEEP]
		& (motion_detect_control_r[pmst_pkg::PMST_LINK_HI:
		pmst_pkg::PMST_LINK_LO] != 2'h0);

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			auto_poll_r <= 1'b0;
		else if (!auto_ok)
			auto_poll_r <= 1'b0;
		else if (inactivity_i)
			auto_poll_r <= 1'b1;
		else
			auto_poll_r <= 1'b0;
	end

	assign poll_mode = power_mode_control_r[pmst_pkg::PMST_BIT_POLL]
		| auto_poll_r;
	assign measuring = power_mode_control_r[pmst_pkg::PMST_ACQ_HI:
		pmst_pkg::PMST_ACQ_LO] == pmst_pkg::PMST_ACQ_ACQUISITION_SELECT;
	assign ext_trig_on = filter_and_rate_control_r[
		pmst_pkg::PMST_BIT_OUTSIDE_SAMPLE_TRIGGER_ON];

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			state_r <= pmst_pkg::PMST_ST_STANDBY;
		else
		begin
			case (state_r)
				pmst_pkg::PMST_ST_STANDBY:
					if (measuring)
						state_r <= poll_mode ? pmst_pkg::PMST_ST_POLL
							: pmst_pkg::PMST_ST_ACQUISITION_SELECT;
				pmst_pkg::PMST_ST_ACQUISITION_SELECT:
					if (!measuring)
						state_r <= pmst_pkg::PMST_ST_STANDBY;
					else if (poll_mode)
						state_r <= pmst_pkg::PMST_ST_POLL;
				pmst_pkg::PMST_ST_POLL:
					if (!measuring)
						state_r <= pmst_pkg::PMST_ST_STANDBY;
					else if (!poll_mode)
						state_r <= pmst_pkg::PMST_ST_ACQUISITION_SELECT;
				default:
					state_r <= pmst_pkg::PMST_ST_STANDBY;
			endcase
		end
	end

	// Rate period in timebase ticks; codes above 400 Hz saturate.
	always_comb
	begin
		case (filter_and_rate_control_r[pmst_pkg::PMST_ODR_HI:
			pmst_pkg::PMST_ODR_LO])
			3'h0: period = 14'(pmst_pkg::PMST_TICKS_100HZ * 8);
			3'h1: period = 14'(pmst_pkg::PMST_TICKS_100HZ * 4);
			3'h2: period = 14'(pmst_pkg::PMST_TICKS_100HZ * 2);
			3'h3: period = 14'(pmst_pkg::PMST_TICKS_100HZ);
			3'h4: period = 14'(pmst_pkg::PMST_TICKS_100HZ / 2);
			default: period = 14'(pmst_pkg::PMST_TICKS_100HZ / 4);
		endcase
		if (state_r == pmst_pkg::PMST_ST_POLL)
			period = 14'(pmst_pkg::PMST_TICKS_POLL);
	end

	pmst_rate_gen u_rate
	(
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.tick_i(tick),
		.run_i(state_r != pmst_pkg::PMST_ST_STANDBY),
		.period_i(period),
		.strobe_o(rate_strobe)
	);

	// Triggered mode drops the internal rate but keeps the filter setting.
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			sample_o <= 1'b0;
			convert_o <= 1'b0;
		end
		else
		begin
			if (state_r == pmst_pkg::PMST_ST_STANDBY)
				sample_o <= 1'b0;
			else if (ext_trig_on)
				sample_o <= trig_rise;
			else
				sample_o <= rate_strobe;
			convert_o <= power_mode_control_r[pmst_pkg::PMST_BIT_CONV_EN]
				& (state_r != pmst_pkg::PMST_ST_STANDBY)
				& (ext_trig_on ? trig_rise : rate_strobe);
		end
	end

	assign ctl.acquire = measuring;
	assign ctl.convert = power_mode_control_r[pmst_pkg::PMST_BIT_CONV_EN];
	assign ctl.stimulus = built_in_force_check_r[pmst_pkg::PMST_BIT_STIM];
	assign ctl.noise = power_mode_control_r[pmst_pkg::PMST_NOISE_HI:
		pmst_pkg::PMST_NOISE_LO];
	assign ctl.filter_bw = filter_and_rate_control_r[pmst_pkg::PMST_ODR_HI:
		pmst_pkg::PMST_ODR_LO];
	assign ctl.half_bw = filter_and_rate_control_r[pmst_pkg::PMST_BIT_HALF_BW];

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			stimulus_o <= 1'b0;
			noise_o <= 2'h0;
			low_rate_poll_mode_o <= 1'b0;
			ext_timebase_o <= 1'b0;
			filter_bw_o <= 4'h0;
			irq_pin_b_oe_n_o <= 1'b1;
		end
		else
		begin
			stimulus_o <= ctl.stimulus;
			// Reserved code 11 falls back to normal operation.
			noise_o <= (ctl.noise == pmst_pkg::PMST_NOISE_RSVD) ?
				pmst_pkg::PMST_NOISE_NORMAL : ctl.noise;
			low_rate_poll_mode_o <= state_r == pmst_pkg::PMST_ST_POLL;
			ext_timebase_o <= power_mode_control_r[pmst_pkg::PMST_BIT_EXT_TB];
			filter_bw_o <= {ctl.half_bw, ctl.filter_bw};
			irq_pin_b_oe_n_o <= 1'b1;
		end
	end

	a_trig_one_sample: assert property (@(posedge ref_clk_i) disable iff
		(srst_i) (ext_trig_on && state_r != pmst_pkg::PMST_ST_STANDBY &&
		trig_rise) |=> sample_o) else $error("trigger lost");
	a_trig_no_rate: assert property (@(posedge ref_clk_i) disable iff
		(srst_i) (ext_trig_on && !trig_rise) |=> !sample_o)
		else $error("sample without trigger");
	a_standby_quiet: assert property (@(posedge ref_clk_i) disable iff
		(srst_i) (state_r == pmst_pkg::PMST_ST_STANDBY) |=> !convert_o)
		else $error("convert in standby");
	a_conv_off: assert property (@(posedge ref_clk_i) disable iff
		(srst_i) !power_mode_control_r[7] |=> !convert_o)
		else $error("converter ran while off");
	a_stim_follow: assert property (@(posedge ref_clk_i) disable iff
		(srst_i) built_in_force_check_r[0] |=> stimulus_o)
		else $error("stimulus missing");
	a_noise_legal: assert property (@(posedge ref_clk_i) disable iff
		(srst_i) noise_o != 2'h3) else $error("reserved noise");
	// Three quiet cycles let an earlier autosleep entry drain out of the state.
	a_auto_ignored: assert property (@(posedge ref_clk_i) disable iff
		(srst_i) (!auto_ok && !power_mode_control_r[3]) [*3]
		|=> !low_rate_poll_mode_o)
		else $error("autosleep not ignored");
	a_ext_tick: assert property (@(posedge ref_clk_i) disable iff
		(srst_i) power_mode_control_r[6] |-> (tick == ext_rise))
		else $error("wrong timebase");

endmodule

// [sim/pmst_far_side.sv]
// Far-side model: free-running outside timebase and sample trigger source.
module pmst_far_side
(
	input wire logic fire_i,
	output logic irq_pin_a_o,
	output logic irq_pin_b_o,
	output logic busy_o
);
	timeunit 1ns;
	timeprecision 1ns;

	time last_rise;
	bit armed;

	// Half period 9770 ns keeps the clock just under 51.2 kHz.
	initial
	begin
		irq_pin_a_o = 1'b0;
		forever #9770 irq_pin_a_o = ~irq_pin_a_o;
	end

	// Pulses keep 1.6 ms between rises, so the rate never passes 625 Hz.
	initial
	begin
		irq_pin_b_o = 1'b0;
		busy_o = 1'b0;
		armed = 1'b0;
		last_rise = 0;
		forever
		begin
			@(posedge fire_i);
			busy_o = 1'b1;
			if (armed && ($time - last_rise < 1600000))
				#(1600000 - ($time - last_rise));
			irq_pin_b_o = 1'b1;
			last_rise = $time;
			armed = 1'b1;
			#26000 irq_pin_b_o = 1'b0;
			#26000 busy_o = 1'b0;
		end
	end
endmodule

// [sim/tb_pmst_top.sv]
// Self-checking bench for power mode and sample timing control.
module tb_pmst_top;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed
	{
		logic [5:0] addr;
		logic [7:0] data;
		logic [7:0] rd;
		logic [8:0] obs;
	} pmst_row_type;

	localparam int N_ROWS = 11;
	// Activity time register sits in the timer range; this block leaves it
	// unmapped, so the write only keeps the host sequence honest.
	localparam logic [5:0] MOTION_DURATION_ADDR = 6'h22;
	localparam pmst_row_type ROWS [N_ROWS] = '{
		'{6'h2D, 8'h10, 8'h10, 9'h01B},
		'{6'h2D, 8'h20, 8'h20, 9'h02B},
		'{6'h2D, 8'h30, 8'h30, 9'h00B},
		'{6'h2D, 8'h0A, 8'h0A, 9'h08B},
		'{6'h2D, 8'h00, 8'h00, 9'h00B},
		'{6'h2E, 8'h01, 8'h01, 9'h04B},
		'{6'h2E, 8'hFE, 8'hFE, 9'h00B},
		'{6'h2D, 8'h40, 8'h40, 9'h10B},
		'{6'h2D, 8'h00, 8'h00, 9'h00B},
		'{6'h2C, 8'h0A, 8'h0A, 9'h002},
		'{6'h3F, 8'h55, 8'h00, 9'h002}
	};

	logic ref_clk_i, srst_i, wr_en_i, inactivity_i, fire;
	logic [5:0] addr_i;
	logic [7:0] wdata_i, rdata_o, d;
	logic pin_a, pin_b, busy, oe_n, sample_o, convert_o, stimulus_o;
	logic poll, ext_tb;
	logic [1:0] noise_o;
	logic [3:0] filter_bw_o;
	logic [8:0] obs;
	int n_errors, checks_done, n_samp, n_conv, cycles;

	assign obs = {ext_tb, poll, stimulus_o, noise_o, filter_bw_o};

	pmst_top u_pmst_top
	(
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.wr_en_i(wr_en_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.rdata_o(rdata_o),
		.inactivity_i(inactivity_i),
		.irq_pin_a_i(pin_a),
		.irq_pin_b_i(pin_b),
		.irq_pin_b_oe_n_o(oe_n),
		.sample_o(sample_o),
		.convert_o(convert_o),
		.stimulus_o(stimulus_o),
		.noise_o(noise_o),
		.low_rate_poll_mode_o(poll),
		.ext_timebase_o(ext_tb),
		.filter_bw_o(filter_bw_o)
	);

	pmst_far_side u_pmst_far_side
	(
		.fire_i(fire),
		.irq_pin_a_o(pin_a),
		.irq_pin_b_o(pin_b),
		.busy_o(busy)
	);

	initial
	begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (sample_o === 1'b1)
			n_samp++;
		if (convert_o === 1'b1)
			n_conv++;
		// The two trigger pulses alone need about 83000 cycles.
		if (cycles == 95000)
		begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_en_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_en_i <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		repeat (2) @(posedge ref_clk_i);
		#1 v = rdata_o;
	endtask

	// Fires one pulse and waits, bounded, for the far side to finish.
	task automatic trigger();
		int k;
		k = 0;
		@(posedge ref_clk_i);
		fire <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		fire <= 1'b0;
		while (busy === 1'b1 && k < 100000)
		begin
			@(posedge ref_clk_i);
			k++;
		end
		repeat (8) @(posedge ref_clk_i);
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		int s0, c0;
		srst_i = 1'b1;
		wr_en_i = 1'b0;
		addr_i = 6'h00;
		wdata_i = 8'h00;
		inactivity_i = 1'b0;
		fire = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		rd(6'h2D, d);
		chk({8'h00, d}, 16'h0000);
		rd(6'h2E, d);
		chk({8'h00, d}, 16'h0000);
		rd(6'h2C, d);
		chk({8'h00, d}, 16'h0013);
		chk({7'h00, obs}, 16'h000B);
		chk({15'h0000, oe_n}, 16'h0001);
		for (int i = 0; i < N_ROWS; i++)
		begin
			wr(ROWS[i].addr, ROWS[i].data);
			rd(ROWS[i].addr, d);
			chk({8'h00, d}, {8'h00, ROWS[i].rd});
			chk({7'h00, obs}, {7'h00, ROWS[i].obs});
		end
		wr(MOTION_DURATION_ADDR, 8'h02);
		// Autosleep must wait for linked or looped motion detection.
		inactivity_i <= 1'b1;
		wr(6'h2D, 8'h06);
		repeat (4) @(posedge ref_clk_i);
		chk({15'h0000, poll}, 16'h0000);
		wr(6'h27, 8'h10);
		repeat (4) @(posedge ref_clk_i);
		chk({15'h0000, poll}, 16'h0001);
		inactivity_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		chk({15'h0000, poll}, 16'h0000);
		wr(6'h27, 8'h00);
		// Trigger in standby is refused; in measurement it samples once.
		wr(6'h2C, 8'h0B);
		wr(6'h2D, 8'h00);
		repeat (3) @(posedge ref_clk_i);
		chk({12'h000, filter_bw_o}, 16'h0003);
		s0 = n_samp;
		c0 = n_conv;
		trigger();
		chk(16'(n_samp - s0), 16'h0000);
		chk(16'(n_conv - c0), 16'h0000);
		wr(6'h2D, 8'h82);
		s0 = n_samp;
		c0 = n_conv;
		trigger();
		chk({15'h0000, busy}, 16'h0000);
		chk(16'(n_samp - s0), 16'h0001);
		chk(16'(n_conv - c0), 16'h0001);
		// A second reset in mid-run restores the power and filter registers.
		wr(6'h2D, 8'h42);
		@(posedge ref_clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		rd(6'h2D, d);
		chk({8'h00, d}, 16'h0000);
		rd(6'h2C, d);
		chk({8'h00, d}, 16'h0013);
		chk({7'h00, obs}, 16'h000B);
		conclude();
	end
endmodule
